// ==== src/flash_host_ctrl.sv ====
// Host-side controller for a byte-wide block-erasable flash.
// Software orders single bus cycles through a small register port;
// the controller times the pins, the reset/power-down line and the
// recovery intervals after it. Pins and inputs share i_mclk.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps

module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter logic [CNT_W-1:0] VALID_CNT = CNT_W'(VALID_CYC),
    parameter logic [CNT_W-1:0] WAKE_CNT  = CNT_W'(WAKE_CYC)
)
(
    input  wire logic              i_mclk,
    input  wire logic              i_rst,
    input  wire logic [7:0]        i_reg_addr,
    input  wire logic [31:0]       i_reg_wdata,
    input  wire logic              i_reg_wr,
    input  wire logic              i_reg_rd,
    output logic      [31:0]       o_reg_rdata,
    output flash_pins_t            o_flash,
    input  wire logic [DATA_W-1:0] i_flash_dq,
    input  wire logic              i_ready_busy_out
);

    // Cycle counts sized to the counter
    localparam logic [CNT_W-1:0] SETUP_N = CNT_W'(WR_SETUP_CYC);
    localparam logic [CNT_W-1:0] PULSE_N = CNT_W'(WR_PULSE_CYC);
    localparam logic [CNT_W-1:0] HOLD_N  = CNT_W'(WR_HOLD_CYC);
    localparam logic [CNT_W-1:0] ACC_N   = CNT_W'(RD_ACCESS_CYC);

    // Registered state
    seq_state_t        state;          // Sequencer state
    logic [CNT_W-1:0]  seq_cnt;        // Cycles left in a phase
    logic [1:0]        ctrl;           // Run and elevated bits
    logic [ADDR_W-1:0] addr;           // Flash address for next cycle
    logic [DATA_W-1:0] wdata;          // Byte for next write cycle
    logic [DATA_W-1:0] rdata;          // Byte caught by last read
    logic [CNT_W-1:0]  valid_cnt;      // Output-valid wait left
    logic [CNT_W-1:0]  wake_cnt;       // Write wake wait left
    logic              refused;        // Sticky: order was refused
    logic [31:0]       reg_rdata;      // Read port data
    flash_pins_t       pins;           // Registered pin values

    // Next values
    seq_state_t        next_state;
    logic [CNT_W-1:0]  next_seq_cnt;
    logic [1:0]        next_ctrl;
    logic [ADDR_W-1:0] next_addr;
    logic [DATA_W-1:0] next_wdata;
    logic [DATA_W-1:0] next_rdata;
    logic [CNT_W-1:0]  next_valid_cnt;
    logic [CNT_W-1:0]  next_wake_cnt;
    logic              next_refused;
    logic [31:0]       next_reg_rdata;
    flash_pins_t       next_pins;

    // Decoded helpers
    logic        go_wr;        // Write order on the port
    logic        go_rd;        // Read order on the port
    logic        rp_up;        // Reset line released
    logic        wake_done;    // Command writes now recognised
    logic        valid_done;   // Read data now trusted
    logic        busy;         // A pin cycle is running
    logic [31:0] status;       // Status word for software

    assign rp_up      = ctrl[CTRL_RUN_BIT];
    assign wake_done  = rp_up && (wake_cnt == '0);
    assign valid_done = rp_up && (valid_cnt == '0);
    assign busy       = (state != S_IDLE);
    assign go_wr = i_reg_wr && (i_reg_addr == REG_GO)
                   && i_reg_wdata[GO_WRITE_BIT];
    assign go_rd = i_reg_wr && (i_reg_addr == REG_GO)
                   && i_reg_wdata[GO_READ_BIT];

    // Status word; device ready/busy level is passed straight up
    always_comb
    begin
        status                 = 32'h0;
        status[ST_BUSY_BIT]    = busy;
        status[ST_RYBY_BIT]    = i_ready_busy_out;
        status[ST_WAKE_BIT]    = wake_done;
        status[ST_VALID_BIT]   = valid_done;
        status[ST_REFUSED_BIT] = refused;
        status[ST_RP_BIT]      = rp_up;
    end

    // Next-value logic for the whole controller except the pins
    always_comb
    begin
        next_state     = state;
        next_seq_cnt   = seq_cnt;
        next_ctrl      = ctrl;
        next_addr      = addr;
        next_wdata     = wdata;
        next_rdata     = rdata;
        next_valid_cnt = valid_cnt;
        next_wake_cnt  = wake_cnt;
        next_refused   = refused;
        next_reg_rdata = 32'h0;

        // Register writes; a write of 1 clears the refused flag
        if (i_reg_wr)
        begin
            case (i_reg_addr)
                REG_CTRL:
                    next_ctrl = i_reg_wdata[1:0];
                REG_ADDR:
                    next_addr = i_reg_wdata[ADDR_W-1:0];
                REG_WDATA:
                    next_wdata = i_reg_wdata[DATA_W-1:0];
                REG_STATUS:
                    if (i_reg_wdata[ST_REFUSED_BIT])
                    begin
                        next_refused = 1'b0;
                    end
                default:
                    next_refused = refused;
            endcase
        end

        // Register reads, answered in the following cycle
        if (i_reg_rd)
        begin
            case (i_reg_addr)
                REG_CTRL:   next_reg_rdata = {30'h0, ctrl};
                REG_ADDR:   next_reg_rdata = {11'h0, addr};
                REG_WDATA:  next_reg_rdata = {24'h0, wdata};
                REG_RDATA:  next_reg_rdata = {24'h0, rdata};
                REG_STATUS: next_reg_rdata = status;
                default:    next_reg_rdata = 32'h0;
            endcase
        end

        // Recovery timers run down only while the line is high
        if (!rp_up)
        begin
            next_valid_cnt = VALID_CNT;
            next_wake_cnt  = WAKE_CNT;
        end
        else
        begin
            if (valid_cnt != '0)
            begin
                next_valid_cnt = valid_cnt - 1'b1;
            end
            if (wake_cnt != '0)
            begin
                next_wake_cnt = wake_cnt - 1'b1;
            end
        end

        // Sequencer
        case (state)
            S_IDLE:
            begin
                // Writes wait for wake, reads for valid outputs
                if (go_wr && wake_done)
                begin
                    next_state   = S_WR_SETUP;
                    next_seq_cnt = SETUP_N;
                end
                else if (go_rd && valid_done)
                begin
                    next_state   = S_RD_WAIT;
                    next_seq_cnt = ACC_N;
                end
                else if (go_wr || go_rd)
                begin
                    next_refused = 1'b1;
                end
            end
            S_WR_SETUP:
            begin
                // Address and data settle before strobe falls
                next_seq_cnt = seq_cnt - 1'b1;
                if (seq_cnt == CNT_W'(1))
                begin
                    next_state   = S_WR_PULSE;
                    next_seq_cnt = PULSE_N;
                end
            end
            S_WR_PULSE:
            begin
                next_seq_cnt = seq_cnt - 1'b1;
                if (seq_cnt == CNT_W'(1))
                begin
                    next_state   = S_WR_HOLD;
                    next_seq_cnt = HOLD_N;
                end
            end
            S_WR_HOLD:
            begin
                // Address and data held after the rising strobe
                next_seq_cnt = seq_cnt - 1'b1;
                if (seq_cnt == CNT_W'(1))
                begin
                    next_state = S_IDLE;
                end
            end
            S_RD_WAIT:
            begin
                next_seq_cnt = seq_cnt - 1'b1;
                if (seq_cnt == CNT_W'(1))
                begin
                    next_rdata = i_flash_dq;
                    next_state = S_IDLE;
                end
            end
            default:
                next_state = S_IDLE;
        endcase

        // Dropping the reset line abandons any cycle in flight; the
        // new run bit is used so the pins go idle at the same edge as
        // the line drops, and no strobe is ever seen in power-down
        if (!next_ctrl[CTRL_RUN_BIT])
        begin
            next_state = S_IDLE;
        end

        // Orders refused while busy; set beats a same-cycle clear
        if ((go_wr || go_rd) && busy)
        begin
            next_refused = 1'b1;
        end
    end

    // Pin values follow the next state so pins change with it
    always_comb
    begin
        next_pins                   = '0;
        next_pins.addr              = next_addr;
        next_pins.dq                = next_wdata;
        next_pins.dq_oe_n           = 1'b1;
        next_pins.ce_n              = 1'b1;
        next_pins.oe_n              = 1'b1;
        next_pins.we_n              = 1'b1;
        next_pins.reset_powerdown_n = next_ctrl[CTRL_RUN_BIT];
        // Elevated level only while the line is released
        next_pins.rp_elevated = next_ctrl[CTRL_RUN_BIT]
                                && next_ctrl[CTRL_HH_BIT];
        case (next_state)
            S_WR_SETUP, S_WR_HOLD:
            begin
                next_pins.ce_n    = 1'b0;
                next_pins.dq_oe_n = 1'b0;
            end
            S_WR_PULSE:
            begin
                next_pins.ce_n    = 1'b0;
                next_pins.dq_oe_n = 1'b0;
                next_pins.we_n    = 1'b0;
            end
            S_RD_WAIT:
            begin
                next_pins.ce_n = 1'b0;
                next_pins.oe_n = 1'b0;
            end
            default:
                next_pins.ce_n = 1'b1;
        endcase
    end

    // State registers; reset holds the flash in power-down
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            state     <= S_IDLE;
            seq_cnt   <= '0;
            ctrl      <= CTRL_RESET;
            addr      <= '0;
            wdata     <= '0;
            rdata     <= '0;
            valid_cnt <= VALID_CNT;
            wake_cnt  <= WAKE_CNT;
            refused   <= 1'b0;
            reg_rdata <= 32'h0;
            pins      <= '{addr: '0, dq: '0, dq_oe_n: 1'b1,
                           ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                           reset_powerdown_n: 1'b0,
                           rp_elevated: 1'b0};
        end
        else
        begin
            state     <= next_state;
            seq_cnt   <= next_seq_cnt;
            ctrl      <= next_ctrl;
            addr      <= next_addr;
            wdata     <= next_wdata;
            rdata     <= next_rdata;
            valid_cnt <= next_valid_cnt;
            wake_cnt  <= next_wake_cnt;
            refused   <= next_refused;
            reg_rdata <= next_reg_rdata;
            pins      <= next_pins;
        end
    end

    // Outputs straight from flip-flops
    assign o_reg_rdata = reg_rdata;
    assign o_flash     = pins;

endmodule

// ==== src/flash_host_pkg.sv ====
// Constants, register map and pin bundle for the flash host controller.
// Assumes one 100 MHz clock and a byte-wide asynchronous flash outside.
package flash_host_pkg;

    // Clock rate used to turn times into cycle counts
    localparam int CLK_MHZ = 100;

    // Flash bus widths and the cycle counter width
    localparam int ADDR_W = 21;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 16;

    // Software register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_GO     = 8'h0C;
    localparam logic [7:0] REG_RDATA  = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;

    // Control register bits and reset value
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_HH_BIT  = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // Go register bits
    localparam int GO_WRITE_BIT = 0;
    localparam int GO_READ_BIT  = 1;

    // Status register bits
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_RYBY_BIT    = 1;
    localparam int ST_WAKE_BIT    = 2;
    localparam int ST_VALID_BIT   = 3;
    localparam int ST_REFUSED_BIT = 4;
    localparam int ST_RP_BIT      = 5;

    // Pin timing, in nanoseconds
    localparam int WR_SETUP_NS = 20;
    localparam int WR_PULSE_NS = 50;
    localparam int WR_HOLD_NS  = 20;
    localparam int RD_ACCESS_NS = 150;
    localparam int RESET_TO_OUTPUT_VALID_NS = 1000;
    localparam int RESET_TO_WRITE_WAKE_NS   = 1000;

    // Least times rounded up to whole cycles
    localparam int WR_SETUP_CYC = (WR_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int WR_PULSE_CYC = (WR_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int WR_HOLD_CYC  = (WR_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int RD_ACCESS_CYC = (RD_ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int VALID_CYC =
        (RESET_TO_OUTPUT_VALID_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_CYC =
        (RESET_TO_WRITE_WAKE_NS * CLK_MHZ + 999) / 1000;

    // Bus cycle sequencer states
    typedef enum logic [2:0] {
        S_IDLE     = 3'b000,
        S_WR_SETUP = 3'b001,
        S_WR_PULSE = 3'b010,
        S_WR_HOLD  = 3'b011,
        S_RD_WAIT  = 3'b100
    } seq_state_t;

    // Flash pins driven by the controller
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq;
        logic              dq_oe_n;
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
        logic              reset_powerdown_n;
        logic              rp_elevated;
    } flash_pins_t;

endpackage

// ==== verif/flash_host_props.sv ====
// Checker for the flash host controller: pin timing and register port.
// Assumes it is bound into flash_host_ctrl and shares its clock.
`timescale 1ns/1ps
module flash_host_props
    import flash_host_pkg::*;
#(
    parameter logic [CNT_W-1:0] VALID_CNT = CNT_W'(VALID_CYC),
    parameter logic [CNT_W-1:0] WAKE_CNT  = CNT_W'(WAKE_CYC)
)
(
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic        i_reg_rd,
    input wire logic [31:0] o_reg_rdata,
    input flash_pins_t      o_flash
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    logic [CNT_W-1:0] up_cnt;      // Cycles since reset line went high
    logic [CNT_W-1:0] next_up_cnt; // Saturates so it never wraps to 0

    // Count up while the flash is out of power-down
    always_comb
    begin
        next_up_cnt = up_cnt;
        if (i_rst || !o_flash.reset_powerdown_n)
            next_up_cnt = '0;
        else if (up_cnt != '1)
            next_up_cnt = up_cnt + 1'b1;
    end

    // Register the counter
    always_ff @(posedge i_mclk)
        up_cnt <= next_up_cnt;

    // Strobe low for five cycles, then high
    sequence s_pulse;
        !o_flash.we_n [*5] ##1 o_flash.we_n;
    endsequence

    // Chip select kept two cycles past the strobe, then dropped
    sequence s_hold;
        !o_flash.ce_n ##1 !o_flash.ce_n ##1 o_flash.ce_n;
    endsequence

    a_setup_before_we: assert property ($fell(o_flash.ce_n) && o_flash.oe_n
        |-> o_flash.we_n [*2] ##1 !o_flash.we_n) else $error("setup short");
    a_we_pulse_len: assert property ($fell(o_flash.we_n) |-> s_pulse)
        else $error("write pulse length wrong");
    a_ce_hold_after: assert property ($rose(o_flash.we_n) |-> s_hold)
        else $error("hold after strobe wrong");
    a_data_at_rise: assert property ($rose(o_flash.we_n)
        |-> $stable(o_flash.addr) && $stable(o_flash.dq) && !o_flash.dq_oe_n)
        else $error("address or data moved at strobe rise");
    a_no_contention: assert property (!o_flash.oe_n
        |-> o_flash.we_n && o_flash.dq_oe_n) else $error("bus contention");
    a_wake_before_write: assert property (!o_flash.we_n
        |-> up_cnt >= WAKE_CNT) else $error("write before wake");
    a_valid_before_read: assert property (!o_flash.oe_n
        |-> up_cnt >= VALID_CNT) else $error("read before valid");
    a_pd_pins_idle: assert property (!o_flash.reset_powerdown_n
        |-> o_flash.we_n && o_flash.ce_n) else $error("cycle in power-down");
    a_rdata_one_cycle: assert property (!$past(i_reg_rd)
        |-> o_reg_rdata == 32'h0) else $error("read data outside slot");
    a_elev_needs_run: assert property (o_flash.rp_elevated
        |-> o_flash.reset_powerdown_n) else $error("elevated in power-down");
endmodule

bind flash_host_ctrl flash_host_props #(
    .VALID_CNT(VALID_CNT),
    .WAKE_CNT (WAKE_CNT)
) i_props (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_reg_rd   (i_reg_rd),
    .o_reg_rdata(o_reg_rdata),
    .o_flash    (o_flash)
);

// ==== verif/flash_dev_model.sv ====
// Behavioural byte-wide flash: byte program, ready/busy, power-down.
// Assumes pins change only on the bench clock; 16 bytes are modelled.
`timescale 1ns/1ps
module flash_dev_model
    import flash_host_pkg::*;
#(
    parameter int WAKE = 4,  // Cycles after reset line rises
    parameter int BUSY = 30, // Program time, kept short
    parameter logic [31:0] LOCK_MAP = 32'h00000002 // Block 1 locked
)
(
    input wire logic          i_mclk,
    input flash_pins_t        i_pins,
    output logic [DATA_W-1:0] o_dq,
    output logic              o_ready_busy_out
);
    logic [DATA_W-1:0] mem [0:15]; // Erased byte-wide window
    logic [DATA_W-1:0] last_dq;    // Last byte put on the bus
    logic              we_q;       // Strobe one cycle ago
    int                busy_cnt;   // Remaining program cycles
    int                wake_cnt;   // Cycles since leaving power-down

    initial
    begin
        for (int i = 0; i < 16; i++)
            mem[i] = 8'hFF;
        last_dq  = 8'h00;
        we_q     = 1'b1;
        busy_cnt = 0;
        wake_cnt = 0;
    end

    // Command write taken on the strobe's rising edge only
    always @(posedge i_mclk)
    begin
        we_q <= i_pins.we_n;
        if (!i_pins.reset_powerdown_n)
        begin
            busy_cnt <= 0;
            wake_cnt <= 0;
        end
        else
        begin
            if (wake_cnt < WAKE)
                wake_cnt <= wake_cnt + 1;
            if (busy_cnt > 0)
                busy_cnt <= busy_cnt - 1;
            // Early or busy writes are dropped, as the real part does
            // Block number is the address above the 64 KB offset; a
            // locked block keeps its data unless the elevated level
            // overrides the lock
            if (i_pins.we_n && !we_q && !i_pins.ce_n && wake_cnt >= WAKE
                && busy_cnt == 0
                && (!LOCK_MAP[i_pins.addr[20:16]]
                    || i_pins.rp_elevated))
            begin
                mem[i_pins.addr[3:0]] <= i_pins.dq;
                busy_cnt              <= BUSY;
            end
        end
        if (!i_pins.ce_n && !i_pins.oe_n)
            last_dq <= o_dq;
    end

    // Read array after power-down; released bus shows a wrong value
    always_comb
        o_dq = (i_pins.reset_powerdown_n && !i_pins.ce_n && !i_pins.oe_n)
            ? mem[i_pins.addr[3:0]] : ~last_dq;

    assign o_ready_busy_out = (busy_cnt == 0);
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the flash host controller.
// Assumes the flash model and the bound checker are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) \
    begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module tb_top
    import flash_host_pkg::*;
();
    logic              mclk;       // Bench clock
    logic              rst;        // Synchronous reset
    logic [7:0]        reg_addr;   // Register port
    logic [31:0]       reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [31:0]       reg_rdata;
    flash_pins_t       pins;       // Controller pins
    logic [DATA_W-1:0] dev_dq;     // Flash data out
    logic [DATA_W-1:0] bus_dq;     // Resolved data bus
    logic              ready_busy; // Flash ready/busy pin
    logic [31:0]       rd;         // Last value read
    int                error_cnt;
    int                check_count;

    // Whoever enables the bus owns it
    assign bus_dq = pins.dq_oe_n ? dev_dq : pins.dq;

    flash_host_ctrl #(
        .VALID_CNT(16'h0004),
        .WAKE_CNT (16'h0004)
    ) i_dut (
        .i_mclk          (mclk),
        .i_rst           (rst),
        .i_reg_addr      (reg_addr),
        .i_reg_wdata     (reg_wdata),
        .i_reg_wr        (reg_wr),
        .i_reg_rd        (reg_rd),
        .o_reg_rdata     (reg_rdata),
        .o_flash         (pins),
        .i_flash_dq      (bus_dq),
        .i_ready_busy_out(ready_busy)
    );

    flash_dev_model i_flash (
        .i_mclk          (mclk),
        .i_pins          (pins),
        .o_dq            (dev_dq),
        .o_ready_busy_out(ready_busy)
    );

    // 100 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // One-cycle write strobe
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Poll one status bit with a bound; running out is a mismatch
    task automatic wait_bit(input int b, input logic v);
        int n;
        n = 0;
        reg_read(REG_STATUS, rd);
        while (rd[b] !== v && n < 200)
        begin
            n++;
            reg_read(REG_STATUS, rd);
        end
        `CHK(rd[b], v)
    endtask

    // Single byte read cycle through the controller
    task automatic flash_read(input logic [31:0] a);
        reg_write(REG_ADDR, a);
        reg_write(REG_GO, 32'h2);
        wait_bit(0, 1'b0);
        reg_read(REG_RDATA, rd);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Tests take under 1000 cycles; allow ten times that
    initial
    begin
        #100000;
        error_cnt++;
        give_verdict();
    end

    // Main sequence
    initial
    begin
        error_cnt   = 0;
        check_count = 0;
        rst         = 1'b1;
        reg_addr    = 8'h00;
        reg_wdata   = 32'h0;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        reg_read(REG_CTRL, rd);
        `CHK(rd, 32'h0)
        reg_read(REG_STATUS, rd);
        `CHK(rd, 32'h2)
        reg_read(8'h20, rd);
        `CHK(rd, 32'h0)
        reg_write(REG_GO, 32'h2);
        reg_read(REG_STATUS, rd);
        `CHK(rd[4], 1'b1)
        $display("test reset_idle done");
        // Command right after leaving power-down must be refused; the
        // flag from the read refusal is cleared first
        reg_write(REG_STATUS, 32'h10);
        reg_write(REG_CTRL, 32'h1);
        reg_write(REG_GO, 32'h1);
        reg_read(REG_STATUS, rd);
        `CHK(rd[4], 1'b1)
        repeat (10) @(posedge mclk);
        reg_write(REG_STATUS, 32'h10);
        reg_read(REG_STATUS, rd);
        `CHK(rd, 32'h2E)
        $display("test wake done");
        // Program, with a second order while busy
        reg_write(REG_ADDR, 32'h5);
        reg_write(REG_WDATA, 32'hA5);
        reg_write(REG_GO, 32'h1);
        reg_write(REG_GO, 32'h1);
        wait_bit(0, 1'b0);
        reg_read(REG_STATUS, rd);
        `CHK(rd[1], 1'b0)
        `CHK(rd[4], 1'b1)
        reg_write(REG_STATUS, 32'h10);
        wait_bit(1, 1'b1);
        flash_read(32'h5);
        `CHK(rd, 32'hA5)
        flash_read(32'h6);
        `CHK(rd, 32'hFF)
        // Program into the locked block must leave it unchanged
        reg_write(REG_ADDR, 32'h10006);
        reg_write(REG_GO, 32'h1);
        wait_bit(0, 1'b0);
        flash_read(32'h10006);
        `CHK(rd, 32'hFF)
        $display("test program done");
        // Power-down in mid read, then back up with elevated level
        reg_write(REG_ADDR, 32'h5);
        reg_write(REG_GO, 32'h2);
        reg_write(REG_CTRL, 32'h0);
        reg_read(REG_STATUS, rd);
        `CHK(rd, 32'h2)
        reg_write(REG_CTRL, 32'h3);
        repeat (10) @(posedge mclk);
        reg_read(REG_STATUS, rd);
        `CHK(rd, 32'h2E)
        `CHK(pins.rp_elevated, 1'b1)
        `CHK(pins.ce_n, 1'b1)
        // Aborted read must not have replaced the last byte read
        reg_read(REG_RDATA, rd);
        `CHK(rd, 32'hFF)
        flash_read(32'h5);
        `CHK(rd, 32'hA5)
        // Elevated level lets the locked block be programmed
        reg_write(REG_ADDR, 32'h10006);
        reg_write(REG_GO, 32'h1);
        wait_bit(0, 1'b0);
        wait_bit(1, 1'b1);
        flash_read(32'h10006);
        `CHK(rd, 32'hA5)
        $display("test power_down done");
        give_verdict();
    end
endmodule
